// File: dv/testbench.sv
// Self-checking bench for the link control and status register block
`timescale 1ns/1ps
module testbench;
  import link_regs_pkg::*;
  // ==========================================================
  // Signals
  logic            ref_clk = 1'b0;
  logic            rst_b   = 1'b0;
  cfg_req_type     cfg_req = '0;
  logic [31:0]     gen_ctrl = 32'h0000_0000;
  logic            common_refclk = 1'b1;
  logic            clkreq_want = 1'b1;
  logic [15:0]     cfg_rdata;
  logic            cfg_rvalid;
  link_policy_type policy;
  logic            clkreq_out;
  logic            completion_128;
  int              err_count = 0;
  int              cmp_count = 0;
  // Rows: write data above, expected readback below
  logic [31:0]     rows [6] = '{32'hFFFF_01CB, 32'h0000_0000, 32'h0041_0041,
                                32'hFE34_0000, 32'h0082_0082, 32'h0108_0108};

  link_ctrl_status_regs uut (.REF_CLK(ref_clk), .RST_B(rst_b), .CFG_REQ(cfg_req), .GEN_CTRL(gen_ctrl),
    .COMMON_REFCLK(common_refclk), .CLKREQ_WANT(clkreq_want), .CFG_RDATA(cfg_rdata),
    .CFG_RVALID(cfg_rvalid), .POLICY(policy), .CLKREQ_OUT(clkreq_out), .COMPLETION_128(completion_128));

  // Clock, 100 ns period
  always #50 ref_clk = ~ref_clk;

  // ==========================================================
  // Tasks
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic do_reset(input logic [31:0] g);
    @(posedge ref_clk);
    gen_ctrl <= g;
    rst_b    <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    cmp("completion_128", 16'h0001, {15'h0000, completion_128});
    cmp("reset_clkreq", 16'h0000, {15'h0000, clkreq_out});
    cmp("reset_rvalid", 16'h0000, {15'h0000, cfg_rvalid});
    cmp("reset_policy", 16'h0000, {9'h000, policy});
    @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic cfg_write(input logic [11:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge ref_clk);
    cfg_req <= '{1'b1, 1'b0, a, be, d};
    @(posedge ref_clk);
    cfg_req <= '0;
  endtask

  task automatic cfg_read(input logic [11:0] a, input logic [15:0] e, input string n);
    @(posedge ref_clk);
    cfg_req <= '{1'b0, 1'b1, a, 2'h0, 16'h0000};
    @(posedge ref_clk);
    cfg_req <= '0;
    #1;
    cmp("rvalid", 16'h0001, {15'h0000, cfg_rvalid});
    cmp(n, e, cfg_rdata);
  endtask

  // Readback of control plus the decoded policy and clock request
  task automatic check_ctrl(input logic [15:0] e);
    link_policy_type ep;
    ep = '{e[7], e[0], e[1], e[6], e[6] ? L0S_LAT_COMMON : L0S_LAT_ASYNC};
    cfg_read(LINK_CTRL_OFFSET, e, "link_ctrl");
    repeat (2) @(posedge ref_clk);
    #1;
    cmp("policy", {9'h000, ep}, {9'h000, policy});
    cmp("clkreq_out", {15'h0000, e[8]}, {15'h0000, clkreq_out});
    cmp("completion_128", 16'h0001, {15'h0000, completion_128});
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    repeat (2000) @(posedge ref_clk);
    err_count++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial begin
    do_reset(32'h2080_0000);
    check_ctrl(16'h0102);
    for (int i = 0; i < 6; i++) begin
      cfg_write(LINK_CTRL_OFFSET, 2'h3, rows[i][31:16]);
      check_ctrl(rows[i][15:0]);
    end
    // Low byte only leaves clock PM enable untouched
    cfg_write(LINK_CTRL_OFFSET, 2'h1, 16'h0000);
    check_ctrl(16'h0100);
    // Clock PM enabled but the core keeps its request: output stays low
    @(posedge ref_clk);
    clkreq_want <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    cmp("clkreq_held", 16'h0000, {15'h0000, clkreq_out});
    @(posedge ref_clk);
    clkreq_want <= 1'b1;
    // Status is read-only; common clock then separate clock
    cfg_write(LINK_STATUS_OFFSET, 2'h3, 16'hFFFF);
    cfg_read(LINK_STATUS_OFFSET, 16'h1011, "link_status");
    common_refclk <= 1'b0;
    repeat (4) @(posedge ref_clk);
    cfg_read(LINK_STATUS_OFFSET, 16'h0011, "link_status");
    cfg_read(12'h084, 16'h0000, "unmapped");
    cmp("clkreq_released", 16'h0001, {15'h0000, clkreq_out});
    // Second reset with zero defaults and clock request wanted
    do_reset(32'h0000_0000);
    check_ctrl(16'h0000);
    report_and_stop();
  end
endmodule

// File: rtl/aspm_decode.sv
// ASPM control field decoder
`timescale 1ns/1ps
module aspm_decode
  import link_regs_pkg::*;
(
  input  wire aspm_type aspm_control,
  output logic          allow_l0s,
  output logic          allow_l1
);

  // ==========================================================
  // Field decode: 00 off, 01 L0s, 10 L1, 11 both
  assign allow_l0s = (aspm_control == ASPM_L0S) || (aspm_control == ASPM_BOTH);
  assign allow_l1  = (aspm_control == ASPM_L1)  || (aspm_control == ASPM_BOTH);

endmodule

// File: rtl/link_ctrl_status_regs.sv
// Link control and link status configuration registers
`timescale 1ns/1ps
module link_ctrl_status_regs
  import link_regs_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire cfg_req_type CFG_REQ,
  input  wire logic [31:0] GEN_CTRL,
  input  wire logic        COMMON_REFCLK,
  input  wire logic        CLKREQ_WANT,
  output logic [15:0]      CFG_RDATA,
  output logic             CFG_RVALID,
  output link_policy_type  POLICY,
  output logic             CLKREQ_OUT,
  output logic             COMPLETION_128
);

  // ==========================================================
  // Pin synchroniser for reference clock strap
  logic scc_meta_q;
  logic scc_sync_q;

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      scc_meta_q <= 1'b0;
      scc_sync_q <= 1'b0;
    end else begin
      scc_meta_q <= COMMON_REFCLK;
      scc_sync_q <= scc_meta_q;
    end
  end

  // ==========================================================
  // Writable link control fields
  logic     clock_pm_enable_q;
  logic     extended_synch_q;
  logic     common_clock_q;
  logic     completion_boundary_select_q;
  aspm_type aspm_control_q;
  logic     defaults_pending_q;

  // Access decode
  wire ctrl_hit    = (CFG_REQ.addr == LINK_CTRL_OFFSET);
  wire status_hit  = (CFG_REQ.addr == LINK_STATUS_OFFSET);
  wire ctrl_wr_lo  = CFG_REQ.wr && ctrl_hit && CFG_REQ.be[0];
  wire ctrl_wr_hi  = CFG_REQ.wr && ctrl_hit && CFG_REQ.be[1];

  // Default-select fields sampled after reset release
  wire       clock_pm_default_select = GEN_CTRL[GEN_CPM_DEF_BIT];
  wire [1:0] aspm_default_select     = GEN_CTRL[GEN_ASPM_DEF_LSB +: 2];

  // Register update; read-only bits have no storage
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      clock_pm_enable_q            <= 1'b0;
      extended_synch_q             <= 1'b0;
      common_clock_q               <= 1'b0;
      completion_boundary_select_q <= 1'b0;
      aspm_control_q               <= ASPM_OFF;
      defaults_pending_q           <= 1'b1;
    end else if (defaults_pending_q) begin
      clock_pm_enable_q  <= clock_pm_default_select;
      aspm_control_q     <= aspm_type'(aspm_default_select);
      defaults_pending_q <= 1'b0;
    end else begin
      if (ctrl_wr_hi) begin
        clock_pm_enable_q <= CFG_REQ.wdata[CTRL_CPM_BIT];
      end
      if (ctrl_wr_lo) begin
        extended_synch_q             <= CFG_REQ.wdata[CTRL_EXT_SYNCH_BIT];
        common_clock_q               <= CFG_REQ.wdata[CTRL_CCC_BIT];
        completion_boundary_select_q <= CFG_REQ.wdata[CTRL_BOUNDARY_BIT];
        aspm_control_q               <= aspm_type'(CFG_REQ.wdata[CTRL_ASPM_LSB +: 2]);
      end
    end
  end

  // ==========================================================
  // Register images
  wire [15:0] ctrl_image = {4'h0,
                            1'b0, 1'b0,
                            1'b0,
                            clock_pm_enable_q,
                            extended_synch_q,
                            common_clock_q,
                            1'b0, 1'b0,
                            completion_boundary_select_q,
                            1'b0,
                            aspm_control_q};
  wire [15:0] status_image = {1'b0, 1'b0,
                              1'b0,
                              scc_sync_q,
                              1'b0, 1'b0,
                              STATUS_WIDTH_CODE,
                              STATUS_SPEED_CODE};
  wire [15:0] rd_mux = ctrl_hit ? ctrl_image : (status_hit ? status_image : 16'h0000);

  // ASPM decode
  logic allow_l0s;
  logic allow_l1;

  aspm_decode u_aspm_decode (
    .aspm_control (aspm_control_q),
    .allow_l0s    (allow_l0s),
    .allow_l1     (allow_l1)
  );

  // ==========================================================
  // Registered outputs
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      CFG_RDATA      <= 16'h0000;
      CFG_RVALID     <= 1'b0;
      POLICY         <= '0;
      CLKREQ_OUT     <= 1'b0;
      COMPLETION_128 <= 1'b1;
    end else begin
      CFG_RVALID     <= CFG_REQ.rd;
      CFG_RDATA      <= CFG_REQ.rd ? rd_mux : 16'h0000;
      POLICY.extended_synch   <= extended_synch_q;
      POLICY.allow_l0s        <= allow_l0s;
      POLICY.allow_l1         <= allow_l1;
      POLICY.common_clock     <= common_clock_q;
      POLICY.l0s_exit_latency <= common_clock_q ? L0S_LAT_COMMON : L0S_LAT_ASYNC;
      CLKREQ_OUT     <= clock_pm_enable_q & CLKREQ_WANT;
      COMPLETION_128 <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  // Accepted write to the low byte, outside the defaults window
  sequence s_lo_write;
    ctrl_wr_lo && !defaults_pending_q;
  endsequence

  // Accepted write to the high byte, outside the defaults window
  sequence s_hi_write;
    ctrl_wr_hi && !defaults_pending_q;
  endsequence

  // First edge after reset release, when the defaults are taken
  sequence s_defaults_load;
    defaults_pending_q;
  endsequence

  // Clock request output
  a_clkreq_low_off: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !clock_pm_enable_q |=> !CLKREQ_OUT)
    else $error("clock request high while disabled");

  // Control readback: hardwired and reserved bits
  a_ctrl_upper_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    CFG_RVALID && $past(ctrl_hit) |-> CFG_RDATA[15:9] == 7'h00)
    else $error("control upper bits set");
  a_bw_irq_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    CFG_RVALID && $past(ctrl_hit) |-> CFG_RDATA[11:10] == 2'h0)
    else $error("bandwidth interrupt enables set");
  a_hw_width_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    CFG_RVALID && $past(ctrl_hit) |-> !CFG_RDATA[9])
    else $error("width change disable set");
  a_ctrl_ro_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    CFG_RVALID && $past(ctrl_hit) |-> CFG_RDATA[5:4] == 2'h0 && !CFG_RDATA[2])
    else $error("control ro bits set");
  a_ctrl_bit2_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    CFG_RVALID && $past(ctrl_hit) |-> !CFG_RDATA[2])
    else $error("control bit 2 set");

  // Status readback and read handshake
  a_status_fixed: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    CFG_RVALID && $past(status_hit) |-> CFG_RDATA[11:0] == 12'h011 && CFG_RDATA[15:13] == 3'h0)
    else $error("status fixed bits wrong");
  a_status_bw_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    CFG_RVALID && $past(status_hit) |-> CFG_RDATA[15:14] == 2'h0)
    else $error("status bandwidth bits set");
  a_scc_follow: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    CFG_RVALID && $past(status_hit) |-> CFG_RDATA[12] == $past(scc_sync_q))
    else $error("scc bit wrong");
  a_rvalid_pulse: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    CFG_REQ.rd |=> CFG_RVALID)
    else $error("read not answered");

  // Exit latency and active state PM policy
  a_latency_sel: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    common_clock_q |=> POLICY.l0s_exit_latency == 3'h3)
    else $error("common latency wrong");
  a_latency_async: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !common_clock_q |=> POLICY.l0s_exit_latency == 3'h4)
    else $error("async latency wrong");
  a_aspm_both: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    aspm_control_q == ASPM_BOTH |=> POLICY.allow_l0s && POLICY.allow_l1)
    else $error("aspm decode wrong");
  a_aspm_l1_only: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    aspm_control_q == ASPM_L1 |=> !POLICY.allow_l0s && POLICY.allow_l1)
    else $error("aspm l1 decode wrong");

  // Stored fields follow accepted writes; own boundary never moves
  a_ccc_write: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    s_lo_write |=> common_clock_q == $past(CFG_REQ.wdata[6]))
    else $error("ccc not stored");
  a_rcb_store: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    s_lo_write |=> completion_boundary_select_q == $past(CFG_REQ.wdata[CTRL_BOUNDARY_BIT]))
    else $error("boundary select not stored");
  a_rcb_fixed: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    ##1 COMPLETION_128)
    else $error("own boundary changed");
  a_cpm_write: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    s_hi_write |=> clock_pm_enable_q == $past(CFG_REQ.wdata[CTRL_CPM_BIT]))
    else $error("clock pm enable not stored");
  a_synch_policy: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    s_lo_write |-> ##2 POLICY.extended_synch == $past(CFG_REQ.wdata[CTRL_EXT_SYNCH_BIT], 2))
    else $error("extended synch not applied");

  // Defaults taken from the general control register after reset
  a_cpm_default: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    s_defaults_load |=> clock_pm_enable_q == $past(clock_pm_default_select))
    else $error("clock pm default wrong");
  a_aspm_default: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    s_defaults_load |=> aspm_control_q == $past(aspm_default_select))
    else $error("aspm default wrong");

endmodule

// File: rtl/link_regs_pkg.sv
// Package: offsets, field positions, fixed status values, codes and field types for the link control/status block
package link_regs_pkg;

  // ==========================================================
  // Register offsets (configuration byte addresses)
  localparam logic [11:0] LINK_CTRL_OFFSET   = 12'h080;
  localparam logic [11:0] LINK_STATUS_OFFSET = 12'h082;

  // ==========================================================
  // Link control field positions
  localparam int CTRL_ASPM_LSB      = 0;
  localparam int CTRL_BOUNDARY_BIT  = 3;
  localparam int CTRL_EXT_SYNCH_BIT = 7;
  localparam int CTRL_CCC_BIT       = 6;
  localparam int CTRL_CPM_BIT       = 8;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'h01CB;

  // ==========================================================
  // General control default-select positions
  localparam int GEN_CPM_DEF_BIT    = 23;
  localparam int GEN_ASPM_DEF_LSB   = 28;

  // ==========================================================
  // Link status fixed values
  localparam logic [3:0] STATUS_SPEED_CODE = 4'h1;
  localparam logic [5:0] STATUS_WIDTH_CODE = 6'h01;
  localparam int         STATUS_SCC_BIT    = 12;

  // ==========================================================
  // Exit latency codes and completion boundary
  localparam logic [2:0] L0S_LAT_COMMON = 3'h3;
  localparam logic [2:0] L0S_LAT_ASYNC  = 3'h4;
  localparam int         OWN_RCB_BYTES  = 128;

  // ==========================================================
  // Active state PM encodings
  typedef enum logic [1:0] {
    ASPM_OFF  = 2'h0,
    ASPM_L0S  = 2'h1,
    ASPM_L1   = 2'h2,
    ASPM_BOTH = 2'h3
  } aspm_type;

  // Configuration access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } cfg_req_type;

  // Decoded link policy outputs
  typedef struct packed {
    logic       extended_synch;
    logic       allow_l0s;
    logic       allow_l1;
    logic       common_clock;
    logic [2:0] l0s_exit_latency;
  } link_policy_type;

endpackage
